// *** rtl/gauge_i2c_pkg.sv ***
// shared constants and types of the fuel-gauge two-wire target port
`default_nettype none
package gauge_i2c_pkg;

    // ****************************************************************
    // bus addressing
    // ****************************************************************
    localparam logic [6:0] TARGET_ADDR = 7'h55;
    localparam logic [7:0] CMD_LAST    = 8'h6b;
    localparam logic [7:0] PTR_RESET   = 8'h00;
    localparam logic [7:0] RDATA_DFLT  = 8'hff;

    // ****************************************************************
    // timing, as times and as cycles of the 40 MHz clock
    // ****************************************************************
    localparam int CLK_HZ      = 40_000_000;
    localparam int STUCK_MS    = 2000;
    localparam int STRETCH_MS  = 80;
    localparam int WAKE_US     = 4000;
    localparam int STUCK_CYC   = CLK_HZ / 1000 * STUCK_MS;
    localparam int STRETCH_CYC = CLK_HZ / 1000 * STRETCH_MS;
    localparam int WAKE_CYC    = CLK_HZ / 1_000_000 * WAKE_US;
    localparam int SETTLE_CYC  = 16;
    localparam int CNT_W       = 22;
    localparam int STUCK_W     = 27;

    // ****************************************************************
    // request kinds passed from the bus side to the access side
    // ****************************************************************
    typedef enum logic [1:0] {REQ_ADDR, REQ_READ, REQ_WRITE} req_kind_t;

endpackage : gauge_i2c_pkg
`default_nettype wire

// *** rtl/gauge_sync.sv ***
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none
module gauge_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = i_d;
        next_q    = meta;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= next_meta;
            o_q  <= next_q;
        end
    end
endmodule : gauge_sync
`default_nettype wire

// *** rtl/gauge_stuck_timer.sv ***
// stuck-low watchdog of the bus lines, on the system clock
`timescale 1ns/1ps
`default_nettype none
module gauge_stuck_timer #(
    parameter int STUCK_CYC = gauge_i2c_pkg::STUCK_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var  logic o_release,
    output var  logic o_sleep_req
);
    localparam int SW = gauge_i2c_pkg::STUCK_W;
    logic          low;
    logic [SW-1:0] cnt;
    logic [SW-1:0] next_cnt;
    logic [4:0]    settle;
    logic [4:0]    next_settle;
    logic          next_release;
    logic          next_sleep_req;

    assign low = ~i_scl | ~i_sda;

    always_comb begin
        next_cnt       = '0;
        next_settle    = '0;
        next_release   = 1'b0;
        next_sleep_req = 1'b0;
        if (low) begin
            next_cnt     = o_release ? cnt : cnt + SW'(1);
            next_release = o_release || (cnt == SW'(STUCK_CYC - 1));
            // our own drivers are off by now, so a line still low is
            // held by someone else: give up and go to sleep
            if (o_release) begin
                next_settle = (settle == 5'(gauge_i2c_pkg::SETTLE_CYC)) ?
                              settle : settle + 5'd1;
                next_sleep_req = (settle == 5'(gauge_i2c_pkg::SETTLE_CYC));
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt         <= '0;
            settle      <= '0;
            o_release   <= 1'b0;
            o_sleep_req <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            settle      <= next_settle;
            o_release   <= next_release;
            o_sleep_req <= next_sleep_req;
        end
    end

    stuck_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        low && !o_release && cnt == SW'(STUCK_CYC - 1) |=> o_release)
        else $error("stuck line not released on time");
    sleep_after_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_sleep_req |-> $past(o_release) && $past(low))
        else $error("sleep requested without a held line");
endmodule : gauge_stuck_timer
`default_nettype wire

// *** rtl/gauge_i2c_target_port.sv ***
// two-wire target port of the fuel gauge: bus engine and access side
// ********************************************************************
// What this block does
// - serve reads, incremental reads, quick reads, writes
// - answer only target address 1010101
// - quick read returns data at current pointer
// - pointer advances on every acknowledged data byte
// - multi-byte writes fill consecutive locations
// - NACK data written to read-only location
// - NACK command byte above 0x6B
// - release both lines after 2 s low
// - line still held after release: go sleep
// - clock stretch at most 80ms, host tolerates
// - while asleep, hold bus up to 4ms
// - wake only on own address
// ********************************************************************
`timescale 1ns/1ps
`default_nettype none
module gauge_i2c_target_port #(
    parameter int STUCK_CYC   = gauge_i2c_pkg::STUCK_CYC,
    parameter int STRETCH_CYC = gauge_i2c_pkg::STRETCH_CYC,
    parameter int WAKE_CYC    = gauge_i2c_pkg::WAKE_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_link_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_scl_out,
    output var  logic       o_scl_oe,
    output var  logic       o_sda_out,
    output var  logic       o_sda_oe,
    input  wire logic       i_oscillator_off_sleep_state,
    output var  logic       o_wake,
    output var  logic       o_sleep_req,
    output var  logic       o_acc_valid,
    output var  logic       o_acc_write,
    output var  logic [7:0] o_acc_addr,
    output var  logic [7:0] o_acc_wdata,
    input  wire logic       i_acc_ready,
    input  wire logic [7:0] i_acc_rdata,
    input  wire logic       i_acc_refused
);
    localparam int CW = gauge_i2c_pkg::CNT_W;
    typedef enum {E_IDLE, E_RX, E_HOLD, E_ACK, E_TX, E_MACK} eng_state_t;
    typedef enum {P_ADDR, P_CMD, P_WDATA, P_RDATA} phase_t;
    typedef enum {S_IDLE, S_WAKE, S_SERVE, S_ACC} acc_state_t;

    // ****************************************************************
    // crossings
    // ****************************************************************
    logic rst_l, scl_s, sda_s, ack_l, rel_l;
    logic scl_c, sda_c, req_c, release_c;
    logic req_tgl, ack_tgl;
    gauge_sync #(.W(1)) u_rst_sync (.i_clk(i_link_clk), .i_rst(1'b0),
        .i_d(i_rst), .o_q(rst_l));
    gauge_sync #(.W(4)) u_link_sync (.i_clk(i_link_clk), .i_rst(rst_l),
        .i_d({release_c, ack_tgl, i_sda, i_scl}),
        .o_q({rel_l, ack_l, sda_s, scl_s}));
    gauge_sync #(.W(3)) u_clk_sync (.i_clk(i_clk), .i_rst(i_rst),
        .i_d({req_tgl, i_sda, i_scl}), .o_q({req_c, sda_c, scl_c}));
    gauge_stuck_timer #(.STUCK_CYC(STUCK_CYC)) u_stuck (.i_clk(i_clk),
        .i_rst(i_rst), .i_scl(scl_c), .i_sda(sda_c),
        .o_release(release_c), .o_sleep_req(o_sleep_req));

    // ****************************************************************
    // bus engine on the link clock
    // ****************************************************************
    eng_state_t              st, next_st;
    phase_t                  ph, next_ph;
    logic [7:0]              shreg, next_shreg, ptr, next_ptr;
    logic [2:0]              bitcnt, next_bitcnt;
    logic                    rw, next_rw, nack, next_nack;
    logic                    next_scl_oe, next_sda_oe, next_req_tgl;
    logic                    scl_d, sda_d;
    gauge_i2c_pkg::req_kind_t req_kind, next_req_kind;
    logic [7:0]              req_addr, next_req_addr;
    logic [7:0]              req_wdata, next_req_wdata;
    logic [7:0]              ack_rdata;
    logic                    ack_refused;
    logic                    busy, start, stop, rise, fall;
    logic [7:0]              rx_byte;

    assign busy    = req_tgl ^ ack_l;
    assign start   = scl_s & scl_d & sda_d & ~sda_s;
    assign stop    = scl_s & scl_d & ~sda_d & sda_s;
    assign rise    = scl_s & ~scl_d;
    assign fall    = ~scl_s & scl_d;
    assign rx_byte = {shreg[6:0], sda_s};

    always_comb begin
        next_st = st;  next_ph = ph;  next_shreg = shreg;  next_ptr = ptr;
        next_bitcnt = bitcnt;  next_rw = rw;  next_nack = nack;
        next_scl_oe = o_scl_oe;  next_sda_oe = o_sda_oe;
        next_req_tgl = req_tgl;  next_req_kind = req_kind;
        next_req_addr = req_addr;  next_req_wdata = req_wdata;
        if (rel_l || stop) begin
            next_st     = E_IDLE;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
        end else if (start) begin
            next_st     = E_RX;
            next_ph     = P_ADDR;
            next_bitcnt = 3'd0;
            next_nack   = 1'b0;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
        end else begin
            case (st)
                E_RX: if (rise) begin
                    next_shreg  = rx_byte;
                    next_bitcnt = bitcnt + 3'd1;
                    if (bitcnt == 3'd7) begin
                        next_st = E_HOLD;
                        case (ph)
                            P_ADDR: if (shreg[6:0] ==
                                        gauge_i2c_pkg::TARGET_ADDR) begin
                                next_rw       = sda_s;
                                next_req_tgl  = ~req_tgl;
                                next_req_kind = gauge_i2c_pkg::REQ_ADDR;
                            end else begin
                                next_st = E_IDLE;
                            end
                            P_CMD: if (rx_byte > gauge_i2c_pkg::CMD_LAST)
                            begin
                                next_nack = 1'b1;
                            end else begin
                                next_ptr = rx_byte;
                            end
                            default: begin
                                next_req_tgl   = ~req_tgl;
                                next_req_kind  = gauge_i2c_pkg::REQ_WRITE;
                                next_req_addr  = ptr;
                                next_req_wdata = rx_byte;
                            end
                        endcase
                    end
                end
                // scl is held low until the access side has answered
                E_HOLD: if (!scl_s) begin
                    next_scl_oe = busy;
                    if (!busy && ph == P_RDATA) begin
                        next_shreg  = ack_rdata;
                        next_sda_oe = ~ack_rdata[7];
                        next_bitcnt = 3'd0;
                        next_st     = E_TX;
                    end else if (!busy) begin
                        if (ph == P_WDATA) begin
                            next_nack = ack_refused;
                        end
                        next_sda_oe = ~((ph == P_WDATA) ? ack_refused : nack);
                        next_st     = E_ACK;
                    end
                end
                E_ACK: if (fall) begin
                    next_sda_oe = 1'b0;
                    next_bitcnt = 3'd0;
                    next_st     = E_RX;
                    if (nack) begin
                        next_st = E_IDLE;
                    end else if (ph == P_ADDR && rw) begin
                        next_req_tgl  = ~req_tgl;
                        next_req_kind = gauge_i2c_pkg::REQ_READ;
                        next_req_addr = ptr;
                        next_ph       = P_RDATA;
                        next_st       = E_HOLD;
                    end else if (ph == P_ADDR) begin
                        next_ph = P_CMD;
                    end else if (ph == P_CMD) begin
                        next_ph = P_WDATA;
                    end else begin
                        next_ptr = ptr + 8'd1;
                    end
                end
                E_TX: if (fall) begin
                    next_bitcnt = bitcnt + 3'd1;
                    if (bitcnt == 3'd7) begin
                        next_sda_oe = 1'b0;
                        next_st     = E_MACK;
                    end else begin
                        next_sda_oe = ~shreg[6];
                        next_shreg  = {shreg[6:0], 1'b0};
                    end
                end
                E_MACK: if (rise) begin
                    next_st = E_IDLE;
                    if (!sda_s) begin
                        next_ptr      = ptr + 8'd1;
                        next_req_tgl  = ~req_tgl;
                        next_req_kind = gauge_i2c_pkg::REQ_READ;
                        next_req_addr = ptr + 8'd1;
                        next_st       = E_HOLD;
                    end
                end
                default: next_st = E_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_l) begin
            st <= E_IDLE;  ph <= P_ADDR;  shreg <= '0;
            ptr <= gauge_i2c_pkg::PTR_RESET;  bitcnt <= '0;
            rw <= 1'b0;  nack <= 1'b0;  o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;  o_scl_out <= 1'b0;  o_sda_out <= 1'b0;
            req_tgl <= 1'b0;  req_kind <= gauge_i2c_pkg::REQ_ADDR;
            req_addr <= '0;  req_wdata <= '0;
            scl_d <= 1'b1;  sda_d <= 1'b1;
        end else begin
            st <= next_st;  ph <= next_ph;  shreg <= next_shreg;
            ptr <= next_ptr;  bitcnt <= next_bitcnt;
            rw <= next_rw;  nack <= next_nack;  o_scl_oe <= next_scl_oe;
            o_sda_oe <= next_sda_oe;  o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;  req_tgl <= next_req_tgl;
            req_kind <= next_req_kind;  req_addr <= next_req_addr;
            req_wdata <= next_req_wdata;
            scl_d <= scl_s;  sda_d <= sda_s;
        end
    end

    // ****************************************************************
    // access side on the system clock
    // ****************************************************************
    acc_state_t cs, next_cs;
    logic       req_seen, next_req_seen, next_ack_tgl, next_wake;
    logic       next_acc_valid, next_acc_write, next_ack_refused;
    logic [7:0] next_acc_addr, next_acc_wdata, next_ack_rdata;
    logic [CW-1:0] cnt, next_cnt;

    always_comb begin
        next_cs = cs;  next_req_seen = req_seen;  next_ack_tgl = ack_tgl;
        next_wake = 1'b0;  next_cnt = cnt + CW'(1);
        next_acc_valid = o_acc_valid;  next_acc_write = o_acc_write;
        next_acc_addr = o_acc_addr;  next_acc_wdata = o_acc_wdata;
        next_ack_rdata = ack_rdata;  next_ack_refused = ack_refused;
        case (cs)
            S_IDLE: begin
                next_cnt = '0;
                if (req_c != req_seen) begin
                    next_req_seen = req_c;
                    next_wake     = i_oscillator_off_sleep_state;
                    next_cs = i_oscillator_off_sleep_state ? S_WAKE : S_SERVE;
                end
            end
            // the bus stays stretched while the core wakes, bounded
            S_WAKE: if (!i_oscillator_off_sleep_state ||
                        cnt == CW'(WAKE_CYC - 1)) begin
                next_cs = S_SERVE;
            end
            S_SERVE: begin
                next_cnt = '0;
                if (req_kind == gauge_i2c_pkg::REQ_ADDR) begin
                    next_ack_tgl = ~ack_tgl;
                    next_cs      = S_IDLE;
                end else begin
                    next_acc_valid = 1'b1;
                    next_acc_write = (req_kind == gauge_i2c_pkg::REQ_WRITE);
                    next_acc_addr  = req_addr;
                    next_acc_wdata = req_wdata;
                    next_cs        = S_ACC;
                end
            end
            S_ACC: if (i_acc_ready ||
                       cnt == CW'(STRETCH_CYC - 1)) begin
                // a slow core is cut off, a write byte refused and a read answered with RDATA_DFLT,
                // so the stretch never passes its bound
                next_acc_valid   = 1'b0;
                next_ack_rdata   = i_acc_ready ? i_acc_rdata :
                                   gauge_i2c_pkg::RDATA_DFLT;
                next_ack_refused = i_acc_ready ? i_acc_refused : 1'b1;
                next_ack_tgl     = ~ack_tgl;
                next_cs          = S_IDLE;
            end
            default: next_cs = S_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs <= S_IDLE;  req_seen <= 1'b0;  ack_tgl <= 1'b0;
            o_wake <= 1'b0;  cnt <= '0;  o_acc_valid <= 1'b0;
            o_acc_write <= 1'b0;  o_acc_addr <= '0;  o_acc_wdata <= '0;
            ack_rdata <= gauge_i2c_pkg::RDATA_DFLT;  ack_refused <= 1'b0;
        end else begin
            cs <= next_cs;  req_seen <= next_req_seen;
            ack_tgl <= next_ack_tgl;  o_wake <= next_wake;  cnt <= next_cnt;
            o_acc_valid <= next_acc_valid;  o_acc_write <= next_acc_write;
            o_acc_addr <= next_acc_addr;  o_acc_wdata <= next_acc_wdata;
            ack_rdata <= next_ack_rdata;  ack_refused <= next_ack_refused;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    addr_filter_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_RX && ph == P_ADDR && rise && bitcnt == 3'd7 && !start &&
        !stop && !rel_l && shreg[6:0] != gauge_i2c_pkg::TARGET_ADDR
        |=> st == E_IDLE && req_tgl == $past(req_tgl))
        else $error("foreign address not ignored");
    cmd_range_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_RX && ph == P_CMD && rise && bitcnt == 3'd7 && !start &&
        !stop && !rel_l && rx_byte > gauge_i2c_pkg::CMD_LAST
        |=> nack ##0 (st == E_HOLD)[*2])
        else $error("command above range not refused");
    ptr_load_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_RX && ph == P_CMD && rise && bitcnt == 3'd7 && !start &&
        !stop && !rel_l && rx_byte <= gauge_i2c_pkg::CMD_LAST
        |=> ptr == $past(rx_byte) && !nack)
        else $error("command byte not loaded into pointer");
    write_inc_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_ACK && fall && ph == P_WDATA && !nack && !start && !stop &&
        !rel_l |=> ptr == $past(ptr) + 8'd1)
        else $error("pointer not advanced on write");
    read_inc_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_MACK && rise && !sda_s && !start && !stop && !rel_l
        |=> ptr == $past(ptr) + 8'd1 && req_addr == ptr && busy)
        else $error("pointer not advanced on read");
    quick_read_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_ACK && fall && ph == P_ADDR && rw && !nack && !start &&
        !stop && !rel_l
        |=> req_kind == gauge_i2c_pkg::REQ_READ && req_addr == $past(ptr))
        else $error("quick read not from pointer");
    ro_nack_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_HOLD && ph == P_WDATA && !scl_s && !busy && ack_refused &&
        !start && !stop && !rel_l |=> !o_sda_oe && st == E_ACK)
        else $error("read-only write acknowledged");
    release_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
        rel_l |=> !o_scl_oe && !o_sda_oe && st == E_IDLE)
        else $error("lines not released after timeout");
    stretch_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cs == S_ACC |-> cnt < CW'(STRETCH_CYC))
        else $error("stretch bound exceeded");
    wake_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cs == S_WAKE |-> cnt < CW'(WAKE_CYC))
        else $error("sleep hold exceeded");
    wake_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cs == S_IDLE && req_c != req_seen && i_oscillator_off_sleep_state
        |=> o_wake ##1 !o_wake)
        else $error("wake not pulsed on own request");

    write_seen_c: cover property (@(posedge i_clk) disable iff (i_rst)
        o_acc_valid && o_acc_write && i_acc_ready);
    incr_read_c: cover property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_MACK && rise && !sda_s ##[1:1000] st == E_MACK && rise);
    quick_read_c: cover property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_ACK && fall && ph == P_ADDR && rw);
    ro_refuse_c: cover property (@(posedge i_link_clk) disable iff (rst_l)
        st == E_ACK && ph == P_WDATA && nack);
endmodule : gauge_i2c_target_port
`default_nettype wire

// *** verif/host_master_model.sv ***
// host master model on the open-drain two-wire lines
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var  logic o_scl_low,
    output var  logic o_sda_low
);
    localparam int Q = 250;
    initial {o_scl_low, o_sda_low} = 2'b00;
    task automatic hi(); // waits out a stretch
        o_scl_low = 1'b0; for (int n = 0; n < 4000 && !i_scl; n++) #10; #Q;
    endtask : hi
    // s high: start or repeated start s low: stop
    task automatic cond(input logic s);
        o_sda_low = !s; #Q; hi(); o_sda_low = s; #Q;
        if (s) begin o_scl_low = 1'b1; #Q; end
    endtask : cond
    task automatic xfer(input logic [7:0] d, input logic m,
                        output logic [7:0] q, output logic a);
        logic [8:0] v, r;
        v = {d, !m};
        for (int i = 8; i >= 0; i--) begin
            o_sda_low = !v[i]; #Q; hi();
            r = {r[7:0], i_sda}; o_scl_low = 1'b1; #Q;
        end
        {q, a, o_sda_low} = {r[8:1], !r[0], 1'b0};
    endtask : xfer
endmodule : host_master_model
`default_nettype wire

// *** verif/gauge_i2c_target_port_tb_top.sv ***
// bench of the two-wire target port with a host model and a store
`timescale 1ns/1ps
`default_nettype none
module gauge_i2c_target_port_tb_top;
    logic       clk = 0, lclk = 0, rst = 1, rdy = 0, rfs = 0;
    logic       vld, wen, scl_oe, sda_oe, h_scl, h_sda, slp;
    logic       scl_o, sda_o, wk, asleep = 0, mute = 0;
    logic [7:0] addr, wdat, rdat = 8'h00, mem [256];
    int         n_fail = 0, total_checks = 0, cyc = 0, n_wake = 0;
    wire        scl = !h_scl && (!scl_oe || scl_o);
    wire        sda = !h_sda && (!sda_oe || sda_o);
    always #12.5 clk = !clk;
    always #6 lclk = !lclk;
    always @(posedge clk) begin // store: from 0x60 up is read-only
        rdy <= vld && !rdy && !mute; rdat <= addr + 8'h40;
        rfs <= wen && addr >= 8'h60; cyc <= cyc + 1;
        n_wake <= n_wake + int'(wk);
        if (vld && rdy && wen && !rfs) mem[addr] <= wdat;
        if (cyc == 60000) begin n_fail++; end_of_test(); end
    end
    // stuck limit sits well above the longest legal low run of a frame
    gauge_i2c_target_port #(.STUCK_CYC(2000), .STRETCH_CYC(100),
        .WAKE_CYC(50))
    dut_u (.i_clk(clk), .i_rst(rst), .i_link_clk(lclk), .i_scl(scl),
        .i_sda(sda), .o_scl_out(scl_o), .o_scl_oe(scl_oe), .o_sda_out(sda_o),
        .o_sda_oe(sda_oe), .i_oscillator_off_sleep_state(asleep), .o_wake(wk),
        .o_sleep_req(slp), .o_acc_valid(vld), .o_acc_write(wen), .o_acc_addr(addr),
        .o_acc_wdata(wdat), .i_acc_ready(rdy), .i_acc_rdata(rdat), .i_acc_refused(rfs));
    host_master_model h (.i_scl(scl), .i_sda(sda), .o_scl_low(h_scl),
        .o_sda_low(h_sda));
    task automatic check(input string s, input logic [7:0] e, g);
        total_checks++; if (g !== e) n_fail++;
        if (g !== e) $display("MISMATCH %s expected %h seen %h", s, e, g);
    endtask : check
    task automatic x(input logic [7:0] d, e, input logic m = 1'b0);
        logic [7:0] q; logic a;
        h.xfer(d, m, q, a);
        check("bus", e, (d == 8'hff) ? q : {7'h00, a});
    endtask : x
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // no checksum or voltage subcommand, no re-read of written data
    // expected, a handful of commands per run
    task automatic gap();
        repeat (2640) @(posedge clk); // 66 us
    endtask : gap
    task automatic t_wake(); // only an own address wakes the core
        int w0;
        w0 = n_wake; @(posedge clk) asleep <= 1'b1;
        h.cond(1'b1); x(8'hac, 8'h00); h.cond(1'b0);
        check("wake", 8'h00, 8'(n_wake - w0));
        h.cond(1'b1); x(8'haa, 8'h01); x(8'h20, 8'h01);
        h.cond(1'b0); check("wake", 8'h01, 8'(n_wake - w0));
        @(posedge clk) asleep <= 1'b0;
        $display("wake test done");
    endtask : t_wake
    task automatic t_slow(); // the store never answers: write byte refused, read byte gives ff
        @(posedge clk) mute <= 1'b1;
        h.cond(1'b1); x(8'haa, 8'h01); x(8'h20, 8'h01);
        x(8'h44, 8'h00); h.cond(1'b1);
        x(8'hab, 8'h01); x(8'hff, 8'hff); h.cond(1'b0);
        @(posedge clk) mute <= 1'b0;
        $display("slow test done");
    endtask : t_slow
    task automatic t_write();
        h.cond(1'b1); x(8'haa, 8'h01); x(8'h10, 8'h01);
        x(8'h11, 8'h01); x(8'h22, 8'h01); h.cond(1'b0); h.cond(1'b1);
        check("mem", 8'h11, mem[16]); check("mem", 8'h22, mem[17]);
        x(8'haa, 8'h01); x(8'h60, 8'h01); x(8'h33, 8'h00);
        h.cond(1'b1); x(8'hac, 8'h00); h.cond(1'b0);
        $display("write test done");
    endtask : t_write
    task automatic t_read();
        h.cond(1'b1); x(8'haa, 8'h01); x(8'h10, 8'h01); h.cond(1'b1);
        x(8'hab, 8'h01); x(8'hff, 8'h50, 1'b1); x(8'hff, 8'h51);
        h.cond(1'b0); gap();
        h.cond(1'b1); x(8'hab, 8'h01); x(8'hff, 8'h51);
        h.cond(1'b1); x(8'haa, 8'h01); x(8'h6c, 8'h00); h.cond(1'b0);
        $display("read test done");
    endtask : t_read
    task automatic t_stuck(); // host parks scl low while the device drives 0
        h.cond(1'b1); x(8'haa, 8'h01); x(8'h10, 8'h01); h.cond(1'b1);
        x(8'hab, 8'h01); repeat (2060) @(posedge clk);
        check("oe", 8'h00, {6'h00, scl_oe, sda_oe});
        check("sleep", 8'h01, {7'h00, slp}); h.cond(1'b0);
        $display("stuck test done");
    endtask : t_stuck
    initial begin
        repeat (3) @(posedge clk); rst <= 1'b0; repeat (10) @(posedge clk);
        t_write(); t_read(); t_wake(); t_slow(); t_stuck(); end_of_test();
    end
endmodule : gauge_i2c_target_port_tb_top
`default_nettype wire
